// *** mlt_pkg.sv ***
// constants, register map and carrier types of the mac address table
`default_nettype none
package mlt_pkg;
	localparam int NPORT = 8;
	localparam int DEPTH = 8192;
	localparam int IW = 13;
	localparam logic [IW-1:0] IDX_LAST = 13'h1fff;
	localparam logic [6:0] STATIC_MAX = 7'h40;
	// time: one second tick derived from the 20 MHz clock
	localparam int CLK_HZ = 20_000_000;
	localparam int SEC_S = 1;
	localparam int SEC_CYCLES = CLK_HZ * SEC_S;
	localparam logic [23:0] AGE_DEF = 24'h00012c;
	localparam logic [23:0] AGE_MIN = 24'h00000a;
	localparam logic [23:0] AGE_MAX = 24'h989680;
	// apb byte offsets
	localparam logic [11:0] REG_CTRL = 12'h000;
	localparam logic [11:0] REG_AGE_TIME = 12'h004;
	localparam logic [11:0] REG_LEARN_MODE = 12'h008;
	localparam logic [11:0] REG_KEY_VID = 12'h00c;
	localparam logic [11:0] REG_KEY_MAC_LO = 12'h010;
	localparam logic [11:0] REG_KEY_MAC_HI = 12'h014;
	localparam logic [11:0] REG_KEY_PORTS = 12'h018;
	localparam logic [11:0] REG_CMD = 12'h01c;
	localparam logic [11:0] REG_STATUS = 12'h020;
	localparam logic [11:0] REG_RES_VID = 12'h024;
	localparam logic [11:0] REG_RES_MAC_LO = 12'h028;
	localparam logic [11:0] REG_RES_MAC_HI = 12'h02c;
	localparam logic [11:0] REG_RES_PORTS = 12'h030;
	// field positions and reset values
	localparam int CTRL_AGE_EN = 0;
	localparam logic CTRL_RESET = 1'b1;
	localparam int ST_BUSY = 0;
	localparam int ST_EOT = 1;
	localparam int ST_OK = 2;
	localparam int ST_CNT_LSB = 8;
	localparam int RES_STATIC = 16;
	// learning modes, two bits per port
	localparam logic [1:0] MODE_AUTO = 2'h0;
	localparam logic [1:0] MODE_OFF = 2'h1;
	localparam logic [1:0] MODE_SECURE = 2'h2;
	localparam logic [15:0] MODE_RESET = 16'h0000;
	// command codes; 1 to 5 are written to the command register, the frame code is used internally only
	localparam logic [2:0] CMD_ADD = 3'h1;
	localparam logic [2:0] CMD_MARK = 3'h2;
	localparam logic [2:0] CMD_COMMIT = 3'h3;
	localparam logic [2:0] CMD_FIND = 3'h4;
	localparam logic [2:0] CMD_NEXT = 3'h5;
	localparam logic [2:0] CMD_FRAME = 3'h6;
	localparam logic [2:0] CMD_NONE = 3'h0;

	typedef enum logic [4:0] {
		S_IDLE  = 5'b00001,
		S_FRAME = 5'b00010,
		S_AGE   = 5'b00100,
		S_MGMT  = 5'b01000,
		S_APPLY = 5'b10000
	} mlt_state_type;

	typedef struct packed {
		logic             valid;
		logic             is_static;
		logic             del_pend;
		logic [11:0]      vid;
		logic [47:0]      mac;
		logic [NPORT-1:0] ports;
		logic [23:0]      stamp;
	} mlt_entry_type;

	typedef struct packed {
		logic [11:0] vid;
		logic [47:0] smac;
		logic [47:0] dmac;
		logic [2:0]  port;
	} mlt_req_type;

	typedef struct packed {
		logic [NPORT-1:0] ports;
		logic             drop;
		logic             dst_hit;
	} mlt_res_type;
endpackage : mlt_pkg
`default_nettype wire

// *** mlt_table.sv ***
// mac address table: forwarding lookup, learning, aging, static entries
//
// The implementer's own choices: register access over APB and the register offsets.
`default_nettype none
module mlt_table #(
	parameter int SEC_CNT = mlt_pkg::SEC_CYCLES
) (
	// clock and reset
	input  wire logic                  pclk,
	input  wire logic                  presetn,
	// apb slave
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [11:0]           paddr,
	input  wire logic [31:0]           pwdata,
	output logic      [31:0]           prdata,
	output logic                       pready,
	output logic                       pslverr,
	// mode lock from another controlling function
	input  wire logic [mlt_pkg::NPORT-1:0] mode_lock,
	// frame lookup request
	input  wire logic                  lkp_valid,
	input  wire mlt_pkg::mlt_req_type  lkp_req,
	output logic                       lkp_ready,
	// frame lookup result
	output logic                       res_valid,
	output mlt_pkg::mlt_res_type       res
);
	import mlt_pkg::*;

	mlt_entry_type    tbl [DEPTH];
	mlt_state_type    state;
	logic [2:0]       op;
	logic [IW-1:0]    idx;
	mlt_entry_type    e;
	logic [59:0]      key_e;
	logic [59:0]      mkey;

	logic             aging_en;
	logic [23:0]      age_time;
	logic [15:0]      learn_mode;
	logic [11:0]      key_vid;
	logic [47:0]      key_mac;
	logic [NPORT-1:0] key_ports;
	logic [2:0]       cmd;
	logic             cmd_pend;
	logic             mgmt_busy;
	logic             eot;
	logic             ok;
	logic [6:0]       stat_cnt;
	mlt_entry_type    best;
	logic             best_have;

	logic [31:0]      sec_div;
	logic             sec_tick;
	logic [23:0]      now;
	logic             age_pend;

	mlt_req_type      rq;
	logic             d_hit;
	logic [NPORT-1:0] d_ports;
	logic             s_hit;
	logic             s_static;
	logic [IW-1:0]    s_idx;
	logic             f_have;
	logic [IW-1:0]    f_idx;
	logic [1:0]       pmode;
	logic [NPORT-1:0] in_bit;

	logic             wr;
	logic             rd;
	logic [23:0]      wage;
	logic             age_out;
	logic             cand;
	logic             go_frame;

	assign e = tbl[idx];
	assign key_e = {e.vid, e.mac};
	assign mkey = {key_vid, key_mac};
	assign wr = psel & penable & pwrite & ~pready;
	assign rd = psel & penable & ~pwrite & ~pready;
	assign pmode = learn_mode[2*rq.port +: 2];
	assign in_bit = NPORT'(1) << rq.port;
	assign go_frame = lkp_valid & lkp_ready;
	assign age_out = e.valid & ~e.is_static & aging_en
		& ((now - e.stamp) >= age_time);
	assign cand = e.valid & ((key_e > mkey)
		| (op == CMD_FIND && key_e == mkey));

	// aging time written out of range is clamped into it
	always_comb begin
		wage = pwdata[23:0];
		if (pwdata < 32'(AGE_MIN))
			wage = AGE_MIN;
		else if (pwdata > 32'(AGE_MAX))
			wage = AGE_MAX;
	end

	// one second tick and the seconds clock used as entry stamps
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sec_div <= 32'h0;
			sec_tick <= 1'b0;
			now <= 24'h0;
		end else begin
			sec_tick <= 1'b0;
			if (sec_div == 32'(SEC_CNT - 1)) begin
				sec_div <= 32'h0;
				sec_tick <= 1'b1;
				now <= now + 24'h1;
			end else begin
				sec_div <= sec_div + 32'h1;
			end
		end
	end

	// a sweep is owed every second; a tick during the start still counts
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			age_pend <= 1'b0;
		else if (sec_tick)
			age_pend <= 1'b1;
		else if (state == S_IDLE && !go_frame)
			age_pend <= 1'b0;
	end

	// apb slave, one wait state on every access
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0;
		end else begin
			pready <= psel & penable & ~pready;
			pslverr <= 1'b0;
			prdata <= 32'h0;
			if (psel & penable & ~pready) begin
				case (paddr)
				REG_CTRL:       prdata <= {31'h0, aging_en};
				REG_AGE_TIME:   prdata <= {8'h0, age_time};
				REG_LEARN_MODE: prdata <= {16'h0, learn_mode};
				REG_KEY_VID:    prdata <= {20'h0, key_vid};
				REG_KEY_MAC_LO: prdata <= key_mac[31:0];
				REG_KEY_MAC_HI: prdata <= {16'h0, key_mac[47:32]};
				REG_KEY_PORTS:  prdata <= {24'h0, key_ports};
				REG_CMD:        prdata <= {29'h0, cmd};
				REG_STATUS: prdata <= {17'h0, stat_cnt, 5'h0, ok, eot,
					mgmt_busy};
				REG_RES_VID: prdata <= {15'h0, best.is_static, 4'h0,
					best.vid};
				REG_RES_MAC_LO: prdata <= best.mac[31:0];
				REG_RES_MAC_HI: prdata <= {16'h0, best.mac[47:32]};
				REG_RES_PORTS:  prdata <= {24'h0, best.ports};
				default:        pslverr <= 1'b1;
				endcase
			end
		end
	end

	// configuration registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			aging_en <= CTRL_RESET;
			age_time <= AGE_DEF;
			learn_mode <= MODE_RESET;
			key_vid <= 12'h0;
			key_mac <= 48'h0;
			key_ports <= '0;
		end else if (wr) begin
			case (paddr)
			REG_CTRL:       aging_en <= pwdata[CTRL_AGE_EN];
			REG_AGE_TIME:   age_time <= wage;
			REG_KEY_VID:    key_vid <= pwdata[11:0];
			REG_KEY_MAC_LO: key_mac[31:0] <= pwdata;
			REG_KEY_MAC_HI: key_mac[47:32] <= pwdata[15:0];
			REG_KEY_PORTS:  key_ports <= pwdata[NPORT-1:0];
			REG_LEARN_MODE: begin
				for (int p = 0; p < NPORT; p++) begin
					if (!mode_lock[p])
						learn_mode[2*p +: 2] <= pwdata[2*p +: 2];
				end
			end
			default: ;
			endcase
		end
	end

	// command register; a write while busy is ignored
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cmd <= CMD_NONE;
			cmd_pend <= 1'b0;
			mgmt_busy <= 1'b0;
		end else begin
			if (wr && paddr == REG_CMD && !mgmt_busy
				&& pwdata[2:0] >= CMD_ADD && pwdata[2:0] <= CMD_NEXT) begin
				cmd <= pwdata[2:0];
				cmd_pend <= 1'b1;
				mgmt_busy <= 1'b1;
			end else begin
				if (state == S_IDLE && !go_frame && !age_pend)
					cmd_pend <= 1'b0;
				if (state == S_APPLY && op != CMD_FRAME)
					mgmt_busy <= 1'b0;
			end
		end
	end

	// engine sequencing: every operation is one pass over all entries
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= S_IDLE;
			op <= CMD_NONE;
			idx <= '0;
			lkp_ready <= 1'b0;
			rq <= '0;
		end else begin
			case (state)
			S_IDLE: begin
				idx <= '0;
				if (go_frame) begin
					lkp_ready <= 1'b0;
					rq <= lkp_req;
					op <= CMD_FRAME;
					state <= S_FRAME;
				end else if (age_pend) begin
					lkp_ready <= 1'b0;
					state <= S_AGE;
				end else if (cmd_pend) begin
					lkp_ready <= 1'b0;
					op <= cmd;
					state <= S_MGMT;
				end else begin
					lkp_ready <= 1'b1;
				end
			end
			S_FRAME, S_MGMT: begin
				idx <= idx + IW'(1);
				if (idx == IDX_LAST)
					state <= S_APPLY;
			end
			S_AGE: begin
				idx <= idx + IW'(1);
				if (idx == IDX_LAST)
					state <= S_IDLE;
			end
			S_APPLY: state <= S_IDLE;
			default: state <= S_IDLE;
			endcase
		end
	end

	// scan accumulators: destination and source hits, free slot, best key
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			d_hit <= 1'b0;
			d_ports <= '0;
			s_hit <= 1'b0;
			s_static <= 1'b0;
			s_idx <= '0;
			f_have <= 1'b0;
			f_idx <= '0;
			best_have <= 1'b0;
		end else if (state == S_IDLE) begin
			d_hit <= 1'b0;
			s_hit <= 1'b0;
			f_have <= 1'b0;
			best_have <= 1'b0;
		end else if (state == S_FRAME || state == S_MGMT) begin
			if (!e.valid && !f_have) begin
				f_have <= 1'b1;
				f_idx <= idx;
			end
			if (state == S_FRAME && e.valid && e.vid == rq.vid) begin
				if (e.mac == rq.dmac) begin
					d_hit <= 1'b1;
					d_ports <= e.ports;
				end
				if (e.mac == rq.smac) begin
					s_hit <= 1'b1;
					s_static <= e.is_static;
					s_idx <= idx;
				end
			end
			if (state == S_MGMT && e.valid && key_e == mkey) begin
				s_hit <= 1'b1;
				s_static <= e.is_static;
				s_idx <= idx;
			end
			if (state == S_MGMT && cand
				&& (!best_have || key_e < {best.vid, best.mac})) begin
				best_have <= 1'b1;
			end
		end
	end

	// enumeration result and command outcome
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			best <= '0;
			eot <= 1'b0;
			ok <= 1'b0;
		end else begin
			if (state == S_MGMT && cand
				&& (!best_have || key_e < {best.vid, best.mac}))
				best <= e;
			if (state == S_APPLY) begin
				case (op)
				CMD_FIND, CMD_NEXT: begin
					eot <= ~best_have;
					ok <= best_have;
				end
				CMD_ADD: ok <= (s_hit & s_static)
					| ((s_hit | f_have) & (stat_cnt < STATIC_MAX));
				CMD_MARK:   ok <= s_hit & s_static;
				CMD_COMMIT: ok <= 1'b1;
				default: ;
				endcase
			end
		end
	end

	// number of static entries held
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			stat_cnt <= 7'h0;
		else if (state == S_MGMT && op == CMD_COMMIT && e.valid
			&& e.del_pend)
			stat_cnt <= stat_cnt - 7'h1;
		else if (state == S_APPLY && op == CMD_ADD && !(s_hit && s_static)
			&& (s_hit || f_have) && stat_cnt < STATIC_MAX)
			stat_cnt <= stat_cnt + 7'h1;
	end

	// the table itself; one writer for all entries
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < DEPTH; i++)
				tbl[i] <= '0;
		end else begin
			case (state)
			S_AGE: begin
				if (age_out)
					tbl[idx].valid <= 1'b0;
			end
			S_MGMT: begin
				if (op == CMD_COMMIT && e.valid && e.del_pend)
					tbl[idx] <= '0;
			end
			S_APPLY: begin
				case (op)
				CMD_FRAME: begin
					if (s_hit && !s_static && pmode != MODE_SECURE) begin
						tbl[s_idx].ports <= in_bit;
						tbl[s_idx].stamp <= now;
					end else if (!s_hit && f_have && pmode == MODE_AUTO) begin
						tbl[f_idx] <= '{valid: 1'b1, is_static: 1'b0,
							del_pend: 1'b0, vid: rq.vid, mac: rq.smac,
							ports: in_bit, stamp: now};
					end
				end
				CMD_ADD: begin
					if (s_hit && s_static) begin
						tbl[s_idx].ports <= key_ports;
						tbl[s_idx].del_pend <= 1'b0;
					end else if ((s_hit || f_have)
						&& stat_cnt < STATIC_MAX) begin
						tbl[s_hit ? s_idx : f_idx] <= '{valid: 1'b1,
							is_static: 1'b1, del_pend: 1'b0, vid: key_vid,
							mac: key_mac, ports: key_ports,
							stamp: now};
					end
				end
				CMD_MARK: begin
					if (s_hit && s_static)
						tbl[s_idx].del_pend <= 1'b1;
				end
				default: ;
				endcase
			end
			default: ;
			endcase
		end
	end

	// frame result: known destination ports, else flood, no ports on a secure drop; never back out
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			res_valid <= 1'b0;
			res <= '0;
		end else begin
			res_valid <= 1'b0;
			if (state == S_APPLY && op == CMD_FRAME) begin
				res_valid <= 1'b1;
				res.dst_hit <= d_hit;
				if (pmode == MODE_SECURE && !(s_hit && s_static)) begin
					res.drop <= 1'b1;
					res.ports <= '0;
				end else begin
					res.drop <= 1'b0;
					res.ports <= (d_hit ? d_ports : '1)
						& ~in_bit;
				end
			end
		end
	end
endmodule : mlt_table
`default_nettype wire

// *** mlt_table_sva.sv ***
// assertions on the ports of the mac address table
`default_nettype none
module mlt_table_sva (
	// clock and reset
	input wire logic                 pclk,
	input wire logic                 presetn,
	// apb slave
	input wire logic                 psel,
	input wire logic                 penable,
	input wire logic                 pready,
	input wire logic                 pslverr,
	// frame lookup
	input wire logic                 lkp_valid,
	input wire mlt_pkg::mlt_req_type lkp_req,
	input wire logic                 lkp_ready,
	input wire logic                 res_valid,
	input wire mlt_pkg::mlt_res_type res
);
	timeunit 1ns;
	timeprecision 1ps;
	import mlt_pkg::*;

	logic [13:0] wait_cnt;
	logic [2:0]  in_port;

	// cycles since a lookup was taken, cleared by its result
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			wait_cnt <= 14'h0000;
		else if (lkp_valid && lkp_ready)
			wait_cnt <= 14'h0001;
		else if (res_valid)
			wait_cnt <= 14'h0000;
		else if (wait_cnt != 14'h0000)
			wait_cnt <= wait_cnt + 14'h0001;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			in_port <= 3'h0;
		else if (lkp_valid && lkp_ready)
			in_port <= lkp_req.port;
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_pready_pulse: assert property (pready |=> !pready)
		else $error("pready held too long");
	a_pready_wait: assert property ((psel && !penable) |=> ##1 pready)
		else $error("apb answer missing");
	a_no_request: assert property (!psel |=> !pready)
		else $error("pready without request");
	a_err_pair: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	a_res_latency: assert property (res_valid |-> wait_cnt == 14'h2002)
		else $error("result at wrong cycle");
	a_res_due: assert property (wait_cnt == 14'h2002 |-> res_valid)
		else $error("result missing");
	a_busy_ready: assert property (wait_cnt != 14'h0000 |-> !lkp_ready)
		else $error("ready while busy");
	a_res_pulse: assert property (res_valid |=> !res_valid)
		else $error("result valid too long");
	a_res_hold: assert property ($changed(res) |-> res_valid)
		else $error("result changed without valid");
	a_no_hairpin: assert property (res_valid |-> !res.ports[in_port])
		else $error("egress includes ingress");
endmodule : mlt_table_sva

bind mlt_table mlt_table_sva u_sva (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pready(pready), .pslverr(pslverr), .lkp_valid(lkp_valid),
	.lkp_req(lkp_req), .lkp_ready(lkp_ready), .res_valid(res_valid),
	.res(res)
);
`default_nettype wire

// *** mlt_frame_src.sv ***
// frame pipeline model: issues one lookup request and holds it until taken
`default_nettype none
module mlt_frame_src (
	// clock and reset
	input  wire logic                 pclk,
	input  wire logic                 presetn,
	// command from the bench
	input  wire logic                 go,
	input  wire mlt_pkg::mlt_req_type req_in,
	// lookup request
	input  wire logic                 lkp_ready,
	output logic                      lkp_valid,
	output mlt_pkg::mlt_req_type      lkp_req
);
	timeunit 1ns;
	timeprecision 1ps;
	import mlt_pkg::*;

	// released request shows inverted data so stale values cannot match
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lkp_valid <= 1'b0;
			lkp_req   <= '0;
		end else if (lkp_valid && lkp_ready) begin
			lkp_valid <= 1'b0;
			lkp_req   <= ~lkp_req;
		end else if (go) begin
			lkp_valid <= 1'b1;
			lkp_req   <= req_in;
		end
	end
endmodule : mlt_frame_src
`default_nettype wire

// *** tb_top.sv ***
// testbench of the mac address table
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import mlt_pkg::*;

	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, d;
	logic [7:0]  mode_lock;
	logic        lkp_valid, lkp_ready, res_valid, go;
	mlt_req_type lkp_req, req_in;
	mlt_res_type res, r;
	int          errors, total_checks, cyc;
	logic        err;

	mlt_table #(.SEC_CNT(200000)) dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .mode_lock(mode_lock),
		.lkp_valid(lkp_valid), .lkp_req(lkp_req), .lkp_ready(lkp_ready),
		.res_valid(res_valid), .res(res));

	mlt_frame_src u_src (
		.pclk(pclk), .presetn(presetn), .go(go), .req_in(req_in),
		.lkp_ready(lkp_ready), .lkp_valid(lkp_valid), .lkp_req(lkp_req));

	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end

	task stop_test;
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : stop_test

	always @(posedge pclk) begin
		cyc++;
		if (cyc == 95000) begin
			errors++;
			stop_test();
		end
	end

	task check(input string name, input logic [31:0] exp, got);
		total_checks++;
		if (got !== exp) begin
			errors++;
			$display("ERROR %s expected %h seen %h", name, exp, got);
		end
	endtask : check

	task apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		d       = prdata;
		err     = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task cmd(input logic [2:0] c, input logic [47:0] mac, input logic [7:0] p);
		apb(1'b1, REG_KEY_VID, 32'h00000001);
		apb(1'b1, REG_KEY_MAC_LO, mac[31:0]);
		apb(1'b1, REG_KEY_MAC_HI, {16'h0000, mac[47:32]});
		apb(1'b1, REG_KEY_PORTS, {24'h000000, p});
		apb(1'b1, REG_CMD, {29'h00000000, c});
		d = 32'h00000001;
		while (d[ST_BUSY] !== 1'b0)
			apb(1'b0, REG_STATUS, 32'h00000000);
	endtask : cmd

	task frame(input logic [2:0] port, input logic [47:0] smac, dmac);
		@(posedge pclk);
		req_in <= '{vid: 12'h001, smac: smac, dmac: dmac, port: port};
		go     <= 1'b1;
		@(posedge pclk);
		go <= 1'b0;
		while (res_valid !== 1'b1)
			@(posedge pclk);
		r = res;
	endtask : frame

	// expects result vid with static flag, mac low word and port set
	task entry(input logic st, input logic [31:0] mac, input logic [7:0] p);
		apb(1'b0, REG_RES_VID, 32'h00000000);
		check("res_vid", {15'h0000, st, 16'h0001}, d & 32'h00010fff);
		apb(1'b0, REG_RES_MAC_LO, 32'h00000000);
		check("res_mac", mac, d);
		apb(1'b0, REG_RES_PORTS, 32'h00000000);
		check("res_ports", {24'h000000, p}, d);
	endtask : entry

	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h00000000;
		mode_lock = 8'h02;
		go = 1'b0;
		req_in = '0;
		errors = 0;
		total_checks = 0;
		cyc = 0;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, REG_CTRL, 32'h00000000);
		check("ctrl", 32'h00000001, d);
		apb(1'b0, REG_AGE_TIME, 32'h00000000);
		check("age_reset", 32'h0000012c, d);
		apb(1'b1, REG_AGE_TIME, 32'h00000005);
		apb(1'b0, REG_AGE_TIME, 32'h00000000);
		check("age_low", 32'h0000000a, d);
		apb(1'b1, REG_AGE_TIME, 32'h00ffffff);
		apb(1'b0, REG_AGE_TIME, 32'h00000000);
		check("age_high", 32'h00989680, d);
		apb(1'b1, REG_CTRL, 32'h00000000);
		apb(1'b0, REG_CTRL, 32'h00000000);
		check("ctrl_off", 32'h00000000, d);
		apb(1'b0, 12'h100, 32'h00000000);
		check("unmapped", 32'h00000001, {31'h0, err});
		// port 1 locked, port 2 secure, port 3 learning off
		apb(1'b1, REG_LEARN_MODE, 32'h00000064);
		apb(1'b0, REG_LEARN_MODE, 32'h00000000);
		check("mode", 32'h00000060, d);
		cmd(CMD_ADD, 48'h000000000010, 8'h30);
		check("st_count", 32'h00000001, {25'h0, d[14:8]});
		frame(3'h0, 48'h000000000020, 48'h000000000010);
		check("fwd_static", 32'h000000c1, {22'h0, r});
		frame(3'h3, 48'h000000000030, 48'h000000000020);
		check("fwd_learned", 32'h00000005, {22'h0, r});
		frame(3'h2, 48'h000000000005, 48'h000000000010);
		check("secure_drop", 32'h1, {31'h0, r.drop});
		cmd(CMD_FIND, 48'h000000000000, 8'h00);
		check("find_ok", 32'h4, d & 32'h00000006);
		entry(1'b1, 32'h00000010, 8'h30);
		cmd(CMD_NEXT, 48'h000000000010, 8'h00);
		entry(1'b0, 32'h00000020, 8'h01);
		cmd(CMD_NEXT, 48'h000000000020, 8'h00);
		check("eot", 32'h2, d & 32'h00000002);
		// marked static entry stays until commit, then is gone
		cmd(CMD_MARK, 48'h000000000010, 8'h00);
		check("mark_ok", 32'h4, d & 32'h00000004);
		check("mark_kept", 32'h00000001, {25'h0, d[14:8]});
		cmd(CMD_COMMIT, 48'h000000000000, 8'h00);
		check("commit_cnt", 32'h00000000, {25'h0, d[14:8]});
		// a fresh add after a commit must count again
		cmd(CMD_ADD, 48'h000000000040, 8'h02);
		check("readd_cnt", 32'h00000001, {25'h0, d[14:8]});
		stop_test();
	end
endmodule : tb_top
`default_nettype wire
